/* hdl/mpd_ram_port.sv */
// RAM-port cycle decoder with AHB-Lite status and control
// Assumes: pins synchronous to clk_sys; single AHB master
`timescale 1ns/1ps
`default_nettype none
`include "mpd_regs.svh"
module mpd_ram_port #(
    parameter int ADDR_W = 9,
    parameter int DQ_W   = 16
) (
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire mpd_pkg::mpd_pins_type pins,
    input  wire logic [ADDR_W-1:0]     addr,
    input  wire logic [DQ_W-1:0]       dq_in,
    input  wire logic                  serial_shift_clock,
    input  wire logic                  serial_port_enable_n,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    output mpd_pkg::mpd_mode_type      cycle_mode,
    output logic [ADDR_W-1:0]          row_addr,
    output logic [ADDR_W-1:0]          col_addr,
    output logic [DQ_W-1:0]            write_mask,
    output logic [DQ_W-1:0]            block_column_mask,
    output logic [DQ_W-1:0]            color_value,
    output logic                       transfer_start,
    output logic                       transfer_to_serial,
    output logic                       ram_output_enable,
    output logic                       serial_output_mode,
    output logic [ADDR_W-1:0]          serial_pointer,
    output logic                       split_half_indicator,
    output logic                       split_half_oe_n
);
    import mpd_pkg::*;

    if (ADDR_W != 9 || DQ_W != 16) begin : g_chk
        $error("mpd_ram_port: only 9 address and 16 data bits");
    end

    // ==========================================
    // Edge detection
    logic ras_prev_q;
    logic cas_prev_q;
    logic sclk_prev_q;
    logic en_q;

    wire ras_fall = ras_prev_q & ~pins.ras_n & en_q;
    wire cas_fall = cas_prev_q & ~pins.cas_n;
    wire step     = ~sclk_prev_q & serial_shift_clock;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ras_prev_q  <= 1'b1;
            cas_prev_q  <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            ras_prev_q  <= pins.ras_n;
            cas_prev_q  <= pins.cas_n;
            sclk_prev_q <= serial_shift_clock;
        end
    end

    // ==========================================
    // Cycle state and sampled levels
    mpd_state_type st_q;
    mpd_state_type st_d;
    mpd_pins_type  lv_q;
    mpd_mode_type  mode_q;
    mpd_mode_type  dec_mode;

    wire mpd_pins_type lv_sel = ras_fall ? pins : lv_q;
    wire col_edge = cas_fall & (st_q != st_standby);
    wire we_low   = ~lv_sel.wel_n | ~lv_sel.weu_n;
    wire masked   = we_low & lv_sel.cas_n;

    mpd_mode_decode u_dec (
        .lv      (lv_sel),
        .dsf_col (pins.special_function_select),
        .mode    (dec_mode)
    );

    assign st_d = pins.ras_n ? st_standby
                : ras_fall   ? st_row
                : col_edge   ? st_col : st_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q   <= st_standby;
            lv_q   <= '1;
            mode_q <= mode_idle;
        end else begin
            st_q <= st_d;
            if (pins.ras_n)
                mode_q <= mode_idle;
            else if (ras_fall | col_edge)
                mode_q <= dec_mode;
            if (ras_fall)
                lv_q <= pins;
        end
    end

    // ==========================================
    // Decoded mode terms
    wire is_cbr     = ras_fall & ~pins.cas_n;
    wire is_xfer    = ras_fall & pins.cas_n & ~pins.xfer_oe_n;
    wire opt_reset  = is_cbr & (dec_mode == mode_refresh_reset_options);
    wire opt_stop   = is_cbr & (dec_mode == mode_refresh_set_stop);
    wire mask_load  = col_edge & (dec_mode == mode_mask_register_load);
    wire color_load = col_edge & (dec_mode == mode_color_register_load);
    wire blk_load   = col_edge & ((dec_mode == mode_masked_block_write)
                    | (dec_mode == mode_unmasked_block_write));
    wire ptr_load   = col_edge & ((dec_mode == mode_read_transfer)
                    | (dec_mode == mode_write_transfer));

    // ==========================================
    // Address latches
    logic [ADDR_W-1:0] row_q;
    logic [ADDR_W-1:0] col_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            row_q <= '0;
            col_q <= '0;
        end else begin
            if (ras_fall)
                row_q <= addr;
            if (col_edge)
                col_q <= addr;
        end
    end

    // ==========================================
    // Mask, color and option registers
    logic [DQ_W-1:0] mask_q;
    logic [DQ_W-1:0] color_q;
    logic [DQ_W-1:0] blk_q;
    logic [7:0]      stop_q;
    logic            persist_q;
    logic            split_q;
    logic            sout_q;
    logic            xfer_q;
    logic            to_ser_q;
    logic            oe_q;

    wire new_mask = ras_fall & masked & ~persist_q;
    wire oe_d     = (st_q != st_standby) & lv_q.xfer_oe_n & lv_q.cas_n
                  & ~pins.xfer_oe_n & ~pins.cas_n & ~pins.ras_n;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mask_q    <= `MPD_MASK_RST;
            persist_q <= 1'b0;
            stop_q    <= `MPD_STOP_RST;
            split_q   <= 1'b0;
        end else if (opt_reset) begin
            mask_q    <= `MPD_MASK_RST;
            persist_q <= 1'b0;
            stop_q    <= `MPD_STOP_RST;
            split_q   <= 1'b0;
        end else begin
            if (new_mask | mask_load) begin
                mask_q    <= dq_in;
                persist_q <= 1'b1;
            end
            if (opt_stop)
                stop_q <= addr[7:0];
            if (is_xfer)
                split_q <= pins.special_function_select;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            color_q  <= `MPD_COLOR_RST;
            blk_q    <= '1;
            sout_q   <= 1'b1;
            xfer_q   <= 1'b0;
            to_ser_q <= 1'b0;
            oe_q     <= 1'b0;
        end else begin
            if (color_load)
                color_q <= dq_in;
            if (blk_load)
                blk_q <= dq_in;
            if (is_xfer) begin
                sout_q   <= ~we_low;
                to_ser_q <= ~we_low;
            end
            xfer_q <= is_xfer;
            oe_q   <= oe_d;
        end
    end

    // ==========================================
    // Serial pointer
    logic [ADDR_W-1:0] ptr_q;

    mpd_serial_ptr #(
        .PTR_W (ADDR_W)
    ) u_ptr (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .step     (step),
        .load     (ptr_load),
        .load_val (addr),
        .split_en (split_q),
        .stop     (stop_q),
        .ptr_q    (ptr_q)
    );

    // ==========================================
    // Device outputs
    wire mode_masked = (mode_q == mode_masked_write)
                     | (mode_q == mode_masked_block_write)
                     | (mode_q == mode_masked_flash_write)
                     | (mode_q == mode_write_transfer)
                     | (mode_q == mode_split_write_transfer);

    assign cycle_mode           = mode_q;
    assign row_addr             = row_q;
    assign col_addr             = col_q;
    assign write_mask           = mode_masked ? mask_q : '1;
    assign block_column_mask    = blk_q;
    assign color_value          = color_q;
    assign transfer_start       = xfer_q;
    assign transfer_to_serial   = to_ser_q;
    assign ram_output_enable    = oe_q;
    assign serial_output_mode   = sout_q;
    assign serial_pointer       = ptr_q;
    assign split_half_indicator = ptr_q[ADDR_W-1];
    assign split_half_oe_n      = serial_port_enable_n;

    // ==========================================
    // AHB-Lite slave, zero wait
    wire       take    = hsel & htrans[1] & hready;
    wire       wr_ctrl = take & hwrite & (haddr[7:0] == `MPD_OFF_CTRL);
    logic      wr_q;
    logic [31:0] rd_q;
    logic [31:0] rd_d;

    wire [31:0] st_word = {20'h0_0000, split_half_indicator, persist_q,
                           split_q, sout_q, 2'b00, st_q, mode_q};

    always_comb begin
        unique case (haddr[7:0])
            `MPD_OFF_CTRL:   rd_d = {31'h0000_0000, en_q};
            `MPD_OFF_STATUS: rd_d = st_word;
            `MPD_OFF_ADDR:   rd_d = {7'h00, col_q, 7'h00, row_q};
            `MPD_OFF_MASK:   rd_d = {16'h0000, mask_q};
            `MPD_OFF_COLOR:  rd_d = {16'h0000, color_q};
            `MPD_OFF_SERIAL: rd_d = {8'h00, stop_q, 7'h00, ptr_q};
            default:         rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_q <= 1'b0;
            rd_q <= 32'h0000_0000;
            en_q <= `MPD_CTRL_EN_RST;
        end else begin
            wr_q <= wr_ctrl;
            if (take & ~hwrite)
                rd_q <= rd_d;
            if (wr_q)
                en_q <= hwdata[`MPD_CTRL_EN_BIT];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rd_q;

    // ==========================================
    // Checks
    sequence s_ras_fall;
        ras_prev_q && !pins.ras_n && en_q;
    endsequence

    sequence s_masked_fall;
        s_ras_fall ##0 pins.cas_n && (!pins.wel_n || !pins.weu_n);
    endsequence

    row_latch_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_ras_fall |=> row_q == $past(addr))
        else $error("row address not latched");

    standby_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        pins.ras_n |=> st_q == st_standby && cycle_mode == mode_idle)
        else $error("port not idle with row strobe high");

    xfer_start_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_ras_fall ##0 pins.cas_n && !pins.xfer_oe_n |=> transfer_start
            ##1 !transfer_start)
        else $error("transfer start pulse wrong");

    oe_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        ram_output_enable |-> $past(!pins.cas_n && !pins.xfer_oe_n)
            && $past(lv_q.xfer_oe_n))
        else $error("output enable without its gates");

    xfer_dir_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_ras_fall ##0 pins.cas_n && !pins.xfer_oe_n
            |=> transfer_to_serial == $past(pins.wel_n && pins.weu_n)
            && serial_output_mode == transfer_to_serial)
        else $error("transfer direction wrong");

    new_mask_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_masked_fall ##0 !persist_q |=> mask_q == $past(dq_in) && persist_q)
        else $error("new mask not sampled");

    old_mask_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_masked_fall ##0 persist_q |=> mask_q == $past(mask_q))
        else $error("persistent mask overwritten");

    opt_reset_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_ras_fall ##0 !pins.cas_n && !pins.special_function_select && pins.wel_n && pins.weu_n
            |=> !persist_q && !split_q && stop_q == `MPD_STOP_RST)
        else $error("reset-options refresh incomplete");

    mode_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st_q == st_col && !pins.ras_n && !cas_fall |=> $stable(cycle_mode)
            && $stable(row_q))
        else $error("mode changed inside row cycle");
endmodule // mpd_ram_port
`default_nettype wire

/* include/mpd_regs.svh */
// Register map and reset values of the RAM-port decoder
// Assumes: included by bare name after the package
`ifndef MPD_REGS_SVH
`define MPD_REGS_SVH

// ==========================================
// Byte offsets
`define MPD_OFF_CTRL    8'h00
`define MPD_OFF_STATUS  8'h04
`define MPD_OFF_ADDR    8'h08
`define MPD_OFF_MASK    8'h0C
`define MPD_OFF_COLOR   8'h10
`define MPD_OFF_SERIAL  8'h14

// ==========================================
// Field positions
`define MPD_CTRL_EN_BIT      0
`define MPD_ST_STATE_LSB     4
`define MPD_ST_SOUT_BIT      8
`define MPD_ST_SPLIT_BIT     9
`define MPD_ST_PERSIST_BIT   10
`define MPD_ST_HALF_BIT      11
`define MPD_HI_FIELD_LSB     16

// ==========================================
// Reset values
`define MPD_CTRL_EN_RST  1'b1
`define MPD_MASK_RST     16'hFFFF
`define MPD_COLOR_RST    16'h0000
`define MPD_STOP_RST     8'hFF

`endif

/* include/mpd_pkg.sv */
// Types shared by the RAM-port decoder files
// Assumes: compiled before all design files
package mpd_pkg;

    // ==========================================
    // Strobe and control pin levels
    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic xfer_oe_n;
        logic wel_n;
        logic weu_n;
        logic special_function_select;
    } mpd_pins_type;

    // ==========================================
    // Cycle operating modes
    typedef enum logic [3:0] {
        mode_idle,
        mode_read_write,
        mode_masked_write,
        mode_masked_block_write,
        mode_masked_flash_write,
        mode_unmasked_block_write,
        mode_mask_register_load,
        mode_color_register_load,
        mode_read_transfer,
        mode_split_read_transfer,
        mode_write_transfer,
        mode_split_write_transfer,
        mode_refresh_reset_options,
        mode_refresh_set_stop,
        mode_refresh_keep_options
    } mpd_mode_type;

    typedef enum logic [1:0] {
        st_standby,
        st_row,
        st_col
    } mpd_state_type;

endpackage

/* hdl/mpd_mode_decode.sv */
// Operating mode decode from strobe-edge levels
// Assumes: levels already captured on the strobe edges
`timescale 1ns/1ps
`default_nettype none
module mpd_mode_decode (
    input  wire mpd_pkg::mpd_pins_type lv,
    input  wire logic                  dsf_col,
    output mpd_pkg::mpd_mode_type      mode
);
    import mpd_pkg::*;

    // ==========================================
    // Level terms
    wire we_low = ~lv.wel_n | ~lv.weu_n;
    wire cbr    = ~lv.cas_n;
    wire xfer   = ~lv.xfer_oe_n;

    always_comb begin
        if (cbr) begin
            if (!lv.special_function_select)
                mode = we_low ? mode_refresh_keep_options
                              : mode_refresh_reset_options;
            else
                mode = we_low ? mode_refresh_set_stop
                              : mode_refresh_keep_options;
        end else if (xfer) begin
            unique case ({we_low, lv.special_function_select})
                2'b00: mode = mode_read_transfer;
                2'b01: mode = mode_split_read_transfer;
                2'b10: mode = mode_write_transfer;
                2'b11: mode = mode_split_write_transfer;
            endcase
        end else if (lv.special_function_select) begin
            if (we_low)
                mode = mode_masked_flash_write;
            else
                mode = dsf_col ? mode_color_register_load
                               : mode_mask_register_load;
        end else if (we_low) begin
            mode = dsf_col ? mode_masked_block_write : mode_masked_write;
        end else begin
            mode = dsf_col ? mode_unmasked_block_write : mode_read_write;
        end
    end
endmodule // mpd_mode_decode
`default_nettype wire

/* hdl/mpd_serial_ptr.sv */
// Serial memory address pointer with split stops
// Assumes: shift step is a one-cycle pulse per shift clock rise
`timescale 1ns/1ps
`default_nettype none
module mpd_serial_ptr #(
    parameter int PTR_W = 9
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic             step,
    input  wire logic             load,
    input  wire logic [PTR_W-1:0] load_val,
    input  wire logic             split_en,
    input  wire logic [PTR_W-2:0] stop,
    output logic      [PTR_W-1:0] ptr_q
);
    import mpd_pkg::*;

    if (PTR_W < 2) begin : g_chk
        $error("mpd_serial_ptr: PTR_W too small");
    end

    // ==========================================
    // Pointer next value
    wire             at_stop = split_en & (ptr_q[PTR_W-2:0] == stop);
    wire [PTR_W-1:0] ptr_inc = ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
    wire [PTR_W-1:0] ptr_jmp = {~ptr_q[PTR_W-1], {(PTR_W-1){1'b0}}};
    wire [PTR_W-1:0] ptr_d   = load ? load_val
                             : at_stop ? ptr_jmp : ptr_inc;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            ptr_q <= '0;
        else if (load | step)
            ptr_q <= ptr_d;
    end

    // ==========================================
    // Checks
    stop_jump_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        step & ~load & at_stop |=> ptr_q[PTR_W-1] != $past(ptr_q[PTR_W-1])
            && ptr_q[PTR_W-2:0] == '0)
        else $error("split stop did not switch halves");
endmodule // mpd_serial_ptr
`default_nettype wire

/* sim/mpd_ctrl_model.sv */
// Strobe controller model for the RAM-port decoder
// Assumes: clk_sys from the bench; pins sampled on its rising edge
`timescale 1ns/1ps
`default_nettype none
module mpd_ctrl_model (
    input  wire logic                 clk_sys,
    output var  mpd_pkg::mpd_pins_type pins,
    output logic [8:0]                addr,
    output logic [15:0]               dq_in,
    output logic                      sc,
    output logic                      se_n,
    output logic                      chk
);
    import mpd_pkg::*;
    initial begin
        pins = 6'b111110;
        addr = 9'h000;
        dq_in = 16'h0000;
        sc = 1'b0;
        se_n = 1'b1;
        chk = 1'b0;
    end
    // ==========================================
    // One RAM cycle: row, then column, then check point
    task automatic cyc(input logic cbr, xo, wl, wu, dr, dc, input logic [8:0] r, c,
                       input logic [15:0] qr, qc);
        @(posedge clk_sys);
        pins <= {1'b1, !cbr, xo, wl, wu, dr};
        addr <= r;
        dq_in <= qr;
        repeat (2) @(posedge clk_sys);
        pins.ras_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        addr <= c;
        dq_in <= qc;
        pins.special_function_select <= dc;
        @(posedge clk_sys);
        if (!cbr) pins.cas_n <= 1'b0;
        if (!cbr && xo) pins.xfer_oe_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        addr <= ~c;
        dq_in <= ~qc;
        chk <= 1'b1;
        @(posedge clk_sys);
        chk <= 1'b0;
        pins.ras_n <= 1'b1;
        pins.cas_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask
    // Single shift clock pulse, clock low at rest
    task automatic shift(input logic en_n);
        @(posedge clk_sys);
        se_n <= en_n;
        sc <= 1'b1;
        @(posedge clk_sys);
        sc <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
endmodule // mpd_ctrl_model
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the RAM-port decoder
// Assumes: package and design compiled first; strobe model in sim/
`timescale 1ns/1ps
`default_nettype none
`include "mpd_regs.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
$display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module testbench;
    import mpd_pkg::*;
    typedef struct packed {
        mpd_mode_type m;
        logic [1:0]   lvl;
        logic [8:0]   r, c;
        logic [15:0]  wm, bm, col;
        logic         so, oe;
    } mpd_exp_type;
    logic         clk_sys, nrst, hsel, hwrite, hready, hresp, chk, sc, se_n, pers, so;
    logic [31:0]  haddr, hwdata, hrdata, rd;
    logic [1:0]   htrans;
    logic [8:0]   addr, row_addr, col_addr, serial_pointer;
    logic [15:0]  dq_in, write_mask, block_column_mask, color_value, msk, color;
    logic         transfer_to_serial, serial_output_mode, split_half_indicator, split_half_oe_n;
    mpd_pins_type pins;
    mpd_mode_type cycle_mode;
    mpd_exp_type  w;
    mpd_exp_type  exp_q[$];
    int           fail_count, cmp_count, xs_n, xs_exp;
    logic [7:0]   stp;
    logic         transfer_start, ram_output_enable;

    mpd_ram_port i_mpd_ram_port (
        .clk_sys(clk_sys), .nrst(nrst), .pins(pins), .addr(addr), .dq_in(dq_in),
        .serial_shift_clock(sc), .serial_port_enable_n(se_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .cycle_mode(cycle_mode),
        .row_addr(row_addr), .col_addr(col_addr), .write_mask(write_mask),
        .block_column_mask(block_column_mask), .color_value(color_value),
        .transfer_start(transfer_start), .transfer_to_serial(transfer_to_serial),
        .ram_output_enable(ram_output_enable),
        .serial_output_mode(serial_output_mode), .serial_pointer(serial_pointer),
        .split_half_indicator(split_half_indicator), .split_half_oe_n(split_half_oe_n));
    mpd_ctrl_model i_mpd_ctrl_model (.clk_sys(clk_sys), .pins(pins), .addr(addr),
        .dq_in(dq_in), .sc(sc), .se_n(se_n), .chk(chk));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // ==========================================
    // Bus and cycle drivers
    task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        q = hrdata;
        `CHK(hresp, 1'b0);
    endtask
    task automatic run(input logic [4:0] k, input logic [8:0] c, input logic [1:0] lvl);
        mpd_exp_type e;
        logic [1:0]  p;
        logic        wl, wu, wlo, mk;
        logic [15:0] qr, qc;
        p = 2'($urandom % 3);
        wl = k[2] | (p == 2'd2);
        wu = k[2] | (p == 2'd1);
        wlo = !(wl & wu);
        qr = 16'($urandom);
        qc = 16'($urandom);
        e.r = 9'($urandom);
        if (k[4]) e.m = k[1] ? (wlo ? mode_refresh_set_stop : mode_refresh_keep_options)
            : (wlo ? mode_refresh_keep_options : mode_refresh_reset_options);
        else if (!k[3]) e.m = wlo ? (k[1] ? mode_split_write_transfer : mode_write_transfer)
            : (k[1] ? mode_split_read_transfer : mode_read_transfer);
        else if (wlo) e.m = k[1] ? mode_masked_flash_write
            : (k[0] ? mode_masked_block_write : mode_masked_write);
        else e.m = k[1] ? (k[0] ? mode_color_register_load : mode_mask_register_load)
            : (k[0] ? mode_unmasked_block_write : mode_read_write);
        mk = e.m inside {mode_masked_write, mode_masked_block_write, mode_masked_flash_write,
            mode_write_transfer, mode_split_write_transfer};
        if (lvl != 2'd2 && !k[4] && !k[3]) xs_exp++;
        if (lvl == 2'd2) e.m = mode_idle;
        else begin
            if (e.m == mode_refresh_reset_options) pers = 1'b0;
            if (e.m == mode_refresh_reset_options) msk = 16'hFFFF;
            if (e.m == mode_refresh_set_stop) stp = e.r[7:0];
            if (e.m == mode_mask_register_load) msk = qc;
            if (e.m == mode_mask_register_load) pers = 1'b1;
            if (mk && !pers) msk = qr;
            if (mk) pers = 1'b1;
            if (e.m == mode_color_register_load) color = qc;
            if (e.m inside {mode_read_transfer, mode_split_read_transfer}) so = 1'b1;
            if (e.m inside {mode_write_transfer, mode_split_write_transfer}) so = 1'b0;
        end
        e.lvl = k[4] ? 2'd1 : lvl;
        e.c = c;
        e.wm = mk ? msk : 16'hFFFF;
        e.bm = qc;
        e.col = color;
        e.so = so;
        e.oe = k[3] & !k[4] & (lvl != 2'd2);
        exp_q.push_back(e);
        i_mpd_ctrl_model.cyc(k[4], k[3], wl, wu, k[1], k[0], e.r, c, qr, qc);
    endtask
    // ==========================================
    // Result watcher
    always @(posedge clk_sys) begin
        if (transfer_start === 1'b1) xs_n++;
        if (chk) begin
            w = exp_q.pop_front();
            `CHK(cycle_mode, w.m);
            `CHK(ram_output_enable, w.oe);
            if (w.lvl != 2'd2) begin
                `CHK(write_mask, w.wm);
                `CHK(color_value, w.col);
                `CHK(serial_output_mode, w.so);
            end
            if (w.lvl == 2'd0) begin
                `CHK(row_addr, w.r);
                `CHK(col_addr, w.c);
            end
            if (w.m inside {mode_masked_block_write, mode_unmasked_block_write})
                `CHK(block_column_mask, w.bm);
            if (w.m inside {mode_read_transfer, mode_split_read_transfer,
                    mode_write_transfer, mode_split_write_transfer})
                `CHK(transfer_to_serial, w.so);
        end
    end
    task automatic end_of_test;
        if (fail_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        $display("[FAIL] %0t timeout", $time);
        end_of_test;
    end
    initial begin
        {nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {msk, pers, color, so} = {16'hFFFF, 1'b0, 16'h0000, 1'b1};
        void'($urandom(96042));
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        ahb(1'b0, {24'h0, `MPD_OFF_CTRL}, 32'h0, rd);
        `CHK(rd[0], `MPD_CTRL_EN_RST);
        ahb(1'b0, 32'h0000_0040, 32'h0, rd);
        `CHK(rd, 32'h0000_0000);
        ahb(1'b1, {24'h0, `MPD_OFF_CTRL}, 32'h0, rd);
        run(5'b01100, 9'h000, 2'd2);
        ahb(1'b1, {24'h0, `MPD_OFF_CTRL}, 32'h1, rd);
        for (int k = 0; k < 96; k++) run(k < 32 ? 5'(k) : 5'($urandom), 9'($urandom), 2'd0);
        run(5'b10100, 9'h000, 2'd0);
        run(5'b10010, 9'h000, 2'd0);
        run(5'b00100, {1'b0, stp}, 2'd0);
        run(5'b00110, 9'h000, 2'd0);
        @(posedge clk_sys);
        `CHK(cycle_mode, mode_idle);
        `CHK(serial_pointer, {1'b0, stp});
        `CHK(split_half_indicator, 1'b0);
        i_mpd_ctrl_model.shift(1'b0);
        `CHK(serial_pointer, 9'h100);
        `CHK(split_half_indicator, 1'b1);
        `CHK(split_half_oe_n, 1'b0);
        i_mpd_ctrl_model.shift(1'b1);
        `CHK(split_half_oe_n, 1'b1);
        `CHK(xs_n, xs_exp);
        end_of_test;
    end
endmodule // testbench
`default_nettype wire
